// ==== design/cbtc_pkg.sv ====
// Constants, register map and state encodings of the CAN bit timing and control block
package cbtc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] CBTC_IDX_CTRL = 16'h1e00;
    localparam logic [15:0] CBTC_IDX_STAT = 16'h1e02;
    localparam logic [15:0] CBTC_IDX_BT0 = 16'h1e3f;
    localparam logic [15:0] CBTC_IDX_BT1 = 16'h1e3e;
    localparam logic [15:0] CBTC_ADDR_CTRL = {CBTC_IDX_CTRL[13:0], 2'b00};
    localparam logic [15:0] CBTC_ADDR_STAT = {CBTC_IDX_STAT[13:0], 2'b00};
    localparam logic [15:0] CBTC_ADDR_BT0 = {CBTC_IDX_BT0[13:0], 2'b00};
    localparam logic [15:0] CBTC_ADDR_BT1 = {CBTC_IDX_BT1[13:0], 2'b00};
    // Control register fields and reset value
    localparam int CBTC_CTRL_INIT = 0;
    localparam int CBTC_CTRL_IE = 1;
    localparam int CBTC_CTRL_SIE = 2;
    localparam int CBTC_CTRL_EIE = 3;
    localparam int CBTC_CTRL_CCE = 6;
    localparam logic [7:0] CBTC_CTRL_RST = 8'h01;
    localparam logic [7:0] CBTC_CTRL_MASK = 8'h4f;
    // Status register fields
    localparam int CBTC_ST_BUSOFF = 0;
    localparam int CBTC_ST_ERRPND = 1;
    localparam int CBTC_ST_STPND = 2;
    localparam int CBTC_ST_ACTIVE = 3;
    localparam int CBTC_ST_RECOV = 4;
    // Timing register fields
    localparam int CBTC_BT0_BRP_LSB = 0;
    localparam int CBTC_BT0_SJW_LSB = 6;
    localparam int CBTC_BT1_PRE_LSB = 0;
    localparam int CBTC_BT1_POST_LSB = 4;
    localparam int CBTC_BT1_SPL = 7;
    // Counts in bits, idle periods and quanta
    localparam int CBTC_IDLE_BITS = 11;
    localparam int CBTC_RECOV_PERIODS = 128;
    localparam logic [4:0] CBTC_TRIPLE_EXTRA = 5'd2;
    // Bit segment and link state encodings
    typedef enum logic [2:0] {
        CBTC_SEG_SYNC = 3'b001,
        CBTC_SEG_PRE = 3'b010,
        CBTC_SEG_POST = 3'b100
    } cbtc_seg_e;
    typedef enum logic [2:0] {
        CBTC_LS_INIT = 3'b001,
        CBTC_LS_WAIT = 3'b010,
        CBTC_LS_ACTIVE = 3'b100
    } cbtc_link_e;
endpackage

// ==== design/cbtc_tq_prescaler.sv ====
// Time quantum prescaler producing one tick per quantum
`timescale 1ns/1ps
module cbtc_tq_prescaler (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] prescale_i,
    output logic tick_o
);
    logic [5:0] cnt_ff;

    // Quantum lasts prescale_i plus one clocks
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 6'h00;
        end else if (cnt_ff >= prescale_i) begin
            cnt_ff <= 6'h00;
        end else begin
            cnt_ff <= cnt_ff + 6'h01;
        end
    end

    assign tick_o = (cnt_ff >= prescale_i);
endmodule

// ==== design/cbtc_run_counter.sv ====
// Saturating-free event counter that pulses when it reaches its limit
`timescale 1ns/1ps
module cbtc_run_counter #(
    parameter int WIDTH = 4,
    parameter int LIMIT = 11
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic inc_i,
    output logic hit_o
);
    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);
    logic [WIDTH-1:0] cnt_ff;

    // Counts events, wraps to zero at the limit; clear wins
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else if (clr_i || (inc_i && cnt_ff == LAST)) begin
            cnt_ff <= '0;
        end else if (inc_i) begin
            cnt_ff <= cnt_ff + WIDTH'(1);
        end
    end

    assign hit_o = inc_i && !clr_i && (cnt_ff == LAST);
endmodule

// ==== design/cbtc_top.sv ====
// CAN bit timing, sampling, link control and APB register file
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module cbtc_top (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rx_i,
    input wire logic frame_active_i,
    input wire logic err_limit_i,
    input wire logic err_evt_i,
    input wire logic stat_evt_i,
    input wire logic obj_irq_req_i,
    output logic tq_tick_o,
    output logic sample_pt_o,
    output logic rx_bit_o,
    output logic tx_point_o,
    output logic bus_enable_o,
    output logic bus_off_o,
    output logic err_clr_o,
    output logic irq_o
);
    import cbtc_pkg::*;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [7:0] ctrl_ff;
    logic [7:0] bt0_ff;
    logic [7:0] bt1_ff;
    logic err_pend_ff;
    logic stat_pend_ff;
    logic bus_off_ff;
    logic recov_ff;
    logic [31:0] prdata_ff;
    logic wr_en;
    logic rd_setup;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_bt0;
    logic hit_bt1;
    logic [31:0] rd_mux;
    logic tick;
    cbtc_seg_e seg_ff;
    logic [4:0] pos_ff;
    logic [4:0] adj_pre_ff;
    logic [4:0] adj_post_ff;
    logic [4:0] carry_ff;
    logic resynced_ff;
    logic edge_ff;
    logic hard_ff;
    logic rx_q_ff;
    logic [1:0] samp_ff;
    logic fall_edge;
    logic [4:0] base_pre;
    logic [4:0] base_post;
    logic [4:0] pre_len;
    logic [4:0] post_len;
    logic [4:0] sjw1;
    logic [4:0] e_raw;
    logic [4:0] e_lim;
    logic [4:0] e_val;
    logic in_sample;
    logic samp_now;
    logic bit_val;
    logic rec_bit;
    logic idle_period;
    logic recov_done;
    logic wait_clr;
    cbtc_link_e link_ff;
    logic [1:0] sync_in_samp;

    // Reset release through two flops
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // APB decode; no wait states, unmapped addresses flag an error
    assign hit_ctrl = (paddr_i == CBTC_ADDR_CTRL);
    assign hit_stat = (paddr_i == CBTC_ADDR_STAT);
    assign hit_bt0 = (paddr_i == CBTC_ADDR_BT0);
    assign hit_bt1 = (paddr_i == CBTC_ADDR_BT1);
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !(hit_ctrl || hit_stat || hit_bt0 || hit_bt1);

    // Read data multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = {24'h00_0000, ctrl_ff};
        end else if (hit_stat) begin
            rd_mux[CBTC_ST_BUSOFF] = bus_off_ff;
            rd_mux[CBTC_ST_ERRPND] = err_pend_ff;
            rd_mux[CBTC_ST_STPND] = stat_pend_ff;
            rd_mux[CBTC_ST_ACTIVE] = (link_ff == CBTC_LS_ACTIVE);
            rd_mux[CBTC_ST_RECOV] = recov_ff;
        end else if (hit_bt0) begin
            rd_mux = {24'h00_0000, bt0_ff};
        end else if (hit_bt1) begin
            rd_mux = {24'h00_0000, bt1_ff};
        end
    end

    // Read data captured in the setup phase, held through the access phase
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= rd_mux;
        end
    end
    assign prdata_o = prdata_ff;

    // Control register; hardware bus-off sets initialization over any clear
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= CBTC_CTRL_RST;
        end else begin
            if (wr_en && hit_ctrl) begin
                ctrl_ff <= pwdata_i[7:0] & CBTC_CTRL_MASK;
            end
            if (err_limit_i) begin
                ctrl_ff[CBTC_CTRL_INIT] <= 1'b1;
            end
        end
    end

    // Timing registers keep their contents through reset, writes gated
    always_ff @(posedge core_clk_i) begin
        if (wr_en && hit_bt0 && ctrl_ff[CBTC_CTRL_CCE]) begin
            bt0_ff <= pwdata_i[7:0];
        end
        if (wr_en && hit_bt1 && ctrl_ff[CBTC_CTRL_CCE]) begin
            bt1_ff <= pwdata_i[7:0];
        end
    end

    // Pending flags: events set them regardless of enables, write one clears
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            err_pend_ff <= 1'b0;
            stat_pend_ff <= 1'b0;
        end else begin
            if (err_evt_i || err_limit_i) begin
                err_pend_ff <= 1'b1;
            end else if (wr_en && hit_stat && pwdata_i[CBTC_ST_ERRPND]) begin
                err_pend_ff <= 1'b0;
            end
            if (stat_evt_i) begin
                stat_pend_ff <= 1'b1;
            end else if (wr_en && hit_stat && pwdata_i[CBTC_ST_STPND]) begin
                stat_pend_ff <= 1'b0;
            end
        end
    end

    // Interrupt request needs global enable; error and status requests also need a source enable, object requests do not
    assign irq_o = ctrl_ff[CBTC_CTRL_IE] && (
        (ctrl_ff[CBTC_CTRL_EIE] && err_pend_ff) ||
        (ctrl_ff[CBTC_CTRL_SIE] && stat_pend_ff) ||
        obj_irq_req_i);

    // Quantum tick source
    cbtc_tq_prescaler u_presc (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .prescale_i(bt0_ff[CBTC_BT0_BRP_LSB +: 6]),
        .tick_o(tick)
    );
    assign tq_tick_o = tick;

    // Effective segment lengths from the programmed fields
    assign base_pre = {1'b0, bt1_ff[CBTC_BT1_PRE_LSB +: 4]} + 5'd1 +
        (bt1_ff[CBTC_BT1_SPL] ? CBTC_TRIPLE_EXTRA : 5'd0);
    assign base_post = {2'b00, bt1_ff[CBTC_BT1_POST_LSB +: 3]} + 5'd1;
    assign pre_len = base_pre + adj_pre_ff;
    assign post_len = base_post - adj_post_ff;
    assign sjw1 = {3'b000, bt0_ff[CBTC_BT0_SJW_LSB +: 2]} + 5'd1;

    // Phase error limited by jump width and by what the post segment can lose
    assign e_raw = (seg_ff == CBTC_SEG_PRE) ? pos_ff : (post_len - pos_ff + 5'd1);
    assign e_lim = (sjw1 < (base_post - 5'd1)) ? sjw1 : (base_post - 5'd1);
    assign e_val = (e_raw < e_lim) ? e_raw : e_lim;

    // Falling edge is recessive to dominant, held until the next quantum
    assign fall_edge = rx_q_ff && !rx_i;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_q_ff <= 1'b1;
            edge_ff <= 1'b0;
            hard_ff <= 1'b0;
        end else begin
            rx_q_ff <= rx_i;
            if (tick) begin
                edge_ff <= fall_edge && frame_active_i;
                hard_ff <= fall_edge && !frame_active_i;
            end else if (fall_edge) begin
                edge_ff <= frame_active_i;
                hard_ff <= !frame_active_i;
            end
        end
    end

    // Sampling window is the last one or three quanta of the pre segment
    assign sync_in_samp = bt1_ff[CBTC_BT1_SPL] ? 2'd2 : 2'd0;
    assign in_sample = (seg_ff == CBTC_SEG_PRE) && (pos_ff + {3'b000, sync_in_samp} >= pre_len);
    assign samp_now = tick && (seg_ff == CBTC_SEG_PRE) && (pos_ff >= pre_len) && !edge_ff;
    assign bit_val = bt1_ff[CBTC_BT1_SPL] ?
        ((samp_ff[1] & samp_ff[0]) | (samp_ff[1] & rx_i) | (samp_ff[0] & rx_i)) : rx_i;

    // Sample shift register
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            samp_ff <= 2'b11;
        end else if (tick && in_sample) begin
            samp_ff <= {samp_ff[0], rx_i};
        end
    end

    // Bit segment sequencer, advanced once per quantum
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seg_ff <= CBTC_SEG_SYNC;
            pos_ff <= 5'd1;
            adj_pre_ff <= 5'd0;
            adj_post_ff <= 5'd0;
            carry_ff <= 5'd0;
            resynced_ff <= 1'b0;
        end else if (tick) begin
            if (hard_ff) begin
                seg_ff <= CBTC_SEG_PRE;
                pos_ff <= 5'd1;
                adj_pre_ff <= 5'd0;
                adj_post_ff <= 5'd0;
                carry_ff <= 5'd0;
                resynced_ff <= 1'b0;
            end else begin
                case (seg_ff)
                    CBTC_SEG_SYNC: begin
                        seg_ff <= CBTC_SEG_PRE;
                        pos_ff <= 5'd1;
                        adj_pre_ff <= carry_ff;
                        adj_post_ff <= 5'd0;
                        carry_ff <= 5'd0;
                        resynced_ff <= 1'b0;
                    end
                    CBTC_SEG_PRE: begin
                        if (edge_ff && !resynced_ff) begin
                            adj_pre_ff <= e_val;
                            adj_post_ff <= e_val;
                            resynced_ff <= 1'b1;
                            pos_ff <= pos_ff + 5'd1;
                        end else if (pos_ff >= pre_len) begin
                            seg_ff <= CBTC_SEG_POST;
                            pos_ff <= 5'd1;
                        end else begin
                            pos_ff <= pos_ff + 5'd1;
                        end
                    end
                    CBTC_SEG_POST: begin
                        if (edge_ff && !resynced_ff) begin
                            adj_post_ff <= e_val;
                            carry_ff <= e_val;
                            resynced_ff <= 1'b1;
                            pos_ff <= pos_ff + 5'd1;
                        end else if (pos_ff >= post_len) begin
                            seg_ff <= CBTC_SEG_SYNC;
                            pos_ff <= 5'd1;
                        end else begin
                            pos_ff <= pos_ff + 5'd1;
                        end
                    end
                    default: begin
                        seg_ff <= CBTC_SEG_SYNC;
                        pos_ff <= 5'd1;
                    end
                endcase
            end
        end
    end

    // Sampled bit and bit-edge strobes
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_bit_o <= 1'b1;
            sample_pt_o <= 1'b0;
            tx_point_o <= 1'b0;
        end else begin
            sample_pt_o <= samp_now;
            if (samp_now) begin
                rx_bit_o <= bit_val;
            end
            tx_point_o <= tick && (seg_ff == CBTC_SEG_POST) && (pos_ff >= post_len) &&
                !edge_ff && (link_ff == CBTC_LS_ACTIVE);
        end
    end

    // Runs of eleven recessive bits form one idle period; restarts while isolated
    assign rec_bit = samp_now && bit_val;
    cbtc_run_counter #(
        .WIDTH(4),
        .LIMIT(CBTC_IDLE_BITS)
    ) u_idle_bits (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .clr_i((samp_now && !bit_val) || (link_ff == CBTC_LS_INIT)),
        .inc_i(rec_bit),
        .hit_o(idle_period)
    );

    // Idle periods counted during bus-off recovery
    assign wait_clr = (link_ff != CBTC_LS_WAIT);
    cbtc_run_counter #(
        .WIDTH(8),
        .LIMIT(CBTC_RECOV_PERIODS)
    ) u_recov (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .clr_i(wait_clr),
        .inc_i(idle_period && recov_ff),
        .hit_o(recov_done)
    );

    // Link state: isolated, waiting for idle, taking part in traffic
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            link_ff <= CBTC_LS_INIT;
            bus_off_ff <= 1'b0;
            recov_ff <= 1'b0;
            err_clr_o <= 1'b0;
        end else begin
            err_clr_o <= 1'b0;
            if (err_limit_i) begin
                link_ff <= CBTC_LS_INIT;
                bus_off_ff <= 1'b1;
                recov_ff <= 1'b0;
            end else begin
                case (link_ff)
                    CBTC_LS_INIT: begin
                        if (!ctrl_ff[CBTC_CTRL_INIT]) begin
                            link_ff <= CBTC_LS_WAIT;
                            recov_ff <= bus_off_ff;
                            err_clr_o <= bus_off_ff;
                        end
                    end
                    CBTC_LS_WAIT: begin
                        if (ctrl_ff[CBTC_CTRL_INIT]) begin
                            link_ff <= CBTC_LS_INIT;
                            recov_ff <= 1'b0;
                        end else if (recov_ff ? recov_done : idle_period) begin
                            link_ff <= CBTC_LS_ACTIVE;
                            bus_off_ff <= 1'b0;
                            recov_ff <= 1'b0;
                        end
                    end
                    CBTC_LS_ACTIVE: begin
                        if (ctrl_ff[CBTC_CTRL_INIT] && !frame_active_i) begin
                            link_ff <= CBTC_LS_INIT;
                        end
                    end
                    default: begin
                        link_ff <= CBTC_LS_INIT;
                    end
                endcase
            end
        end
    end

    assign bus_enable_o = (link_ff == CBTC_LS_ACTIVE);
    assign bus_off_o = bus_off_ff;
endmodule

// ==== dv/cbtc_bus_node.sv ====
// Behavioural far-side node that can hold the shared bus dominant
`timescale 1ns/1ps
module cbtc_bus_node (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [15:0] len_i,
    output logic rx_o
);
    int left = 0;
    // Counts down the dominant stretch requested by the bench
    always @(posedge clk_i) begin
        if (go_i) begin
            left <= len_i;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    // A released bus is pulled to the recessive level
    assign rx_o = (left == 0);
endmodule

// ==== dv/cbtc_top_asserts.sv ====
// Concurrent checks on the ports of the bit timing and control block
`timescale 1ns/1ps
module cbtc_top_asserts
    import cbtc_pkg::*;
(
    input wire logic core_clk_i, arst_n_i, psel_i, penable_i, pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic pready_o, pslverr_o, rx_i, frame_active_i, err_limit_i, err_evt_i,
    input wire logic stat_evt_i, obj_irq_req_i, tq_tick_o, sample_pt_o, rx_bit_o,
    input wire logic tx_point_o, bus_enable_o, bus_off_o, err_clr_o, irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic wr, ie_ff, cce_ff, brp_ok_ff;
    logic [5:0] brp_ff;
    logic [7:0] calm_ff;
    logic [6:0] gap_ff;
    assign wr = psel_i & penable_i & pwrite_i;
    // Shadow of global enable and prescaler as written over the bus
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ie_ff <= 1'b0;
            cce_ff <= 1'b0;
            brp_ok_ff <= 1'b0;
            calm_ff <= 8'h00;
        end else begin
            calm_ff <= (calm_ff == 8'hff) ? calm_ff : calm_ff + 8'h01;
            if (wr && paddr_i == CBTC_ADDR_CTRL) begin
                ie_ff <= pwdata_i[1];
                cce_ff <= pwdata_i[6];
            end
            if (wr && paddr_i == CBTC_ADDR_BT0 && cce_ff) begin
                brp_ff <= pwdata_i[5:0];
                brp_ok_ff <= 1'b1;
                calm_ff <= 8'h00;
            end
        end
    end
    // Clocks since the previous quantum tick
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap_ff <= 7'h00;
        end else begin
            gap_ff <= tq_tick_o ? 7'h01 : ((gap_ff == 7'h7f) ? gap_ff : gap_ff + 7'h01);
        end
    end
    a_tick_spacing: assert property (tq_tick_o && brp_ok_ff && calm_ff >= 8'd130
        |-> gap_ff == {1'b0, brp_ff} + 7'h01) else $error("quantum length wrong");
    a_sample_after_tick: assert property (sample_pt_o |-> $past(tq_tick_o))
        else $error("sample point not after a tick");
    a_tx_needs_bus: assert property (tx_point_o |-> bus_enable_o || $past(bus_enable_o))
        else $error("transmit point while isolated");
    a_busoff_isolate: assert property (err_limit_i |=> bus_off_o && !bus_enable_o)
        else $error("error limit did not isolate");
    a_busoff_holds: assert property (bus_off_o |-> !bus_enable_o)
        else $error("bus enabled while bus off");
    a_irq_global: assert property (irq_o |-> ie_ff)
        else $error("request without global enable");
    a_obj_irq: assert property (obj_irq_req_i && ie_ff |-> irq_o)
        else $error("object request not raised");
    a_err_clr_pulse: assert property (err_clr_o |=> !err_clr_o)
        else $error("counter clear longer than a clock");
endmodule
bind cbtc_top cbtc_top_asserts cbtc_top_asserts_inst (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_i(rx_i), .frame_active_i(frame_active_i),
    .err_limit_i(err_limit_i), .err_evt_i(err_evt_i), .stat_evt_i(stat_evt_i),
    .obj_irq_req_i(obj_irq_req_i), .tq_tick_o(tq_tick_o), .sample_pt_o(sample_pt_o),
    .rx_bit_o(rx_bit_o), .tx_point_o(tx_point_o), .bus_enable_o(bus_enable_o),
    .bus_off_o(bus_off_o), .err_clr_o(err_clr_o), .irq_o(irq_o));

// ==== dv/test_can_bit_timing_and_control.sv ====
// Self-checking bench for the CAN bit timing and control block
`timescale 1ns/1ps
module test_can_bit_timing_and_control;
    import cbtc_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, fa = 0, elim = 0, eev = 0;
    logic sev = 0, obj = 0, go = 0, eseen, clr_seen = 0;
    logic [15:0] pa = 0, dlen = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic prdy, perr, rx, tick, spt, rbit, txp, ben, boff, eclr, irq;
    int fail_count = 0, comparisons = 0, n, b, t1, t2, sp;
    initial forever #2.5 clk = ~clk;
    cbtc_top cbtc_top_inst (.core_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .rx_i(rx), .frame_active_i(fa), .err_limit_i(elim),
        .err_evt_i(eev), .stat_evt_i(sev), .obj_irq_req_i(obj), .tq_tick_o(tick),
        .sample_pt_o(spt), .rx_bit_o(rbit), .tx_point_o(txp), .bus_enable_o(ben),
        .bus_off_o(boff), .err_clr_o(eclr), .irq_o(irq));
    cbtc_bus_node cbtc_bus_node_inst (.clk_i(clk), .go_i(go), .len_i(dlen), .rx_o(rx));
    // Latches any counter-clear pulse
    always @(posedge clk) if (eclr === 1'b1) clr_seen <= 1'b1;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready; one idle cycle follows
    task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        eseen = perr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
        apb(0, a, 8'h00);
        chk(nm, e, rd);
    endtask
    // Clocks between two consecutive sample points (s=0) or transmit points (s=1)
    task gap(input int s, output int g);
        g = 0;
        do @(posedge clk); while ((s ? txp : spt) !== 1'b1);
        do begin
            @(posedge clk);
            g++;
        end while ((s ? txp : spt) !== 1'b1);
    endtask
    // Sample points counted until the controller joins the bus
    task join_count(output int c);
        c = 0;
        while (ben !== 1'b1) begin
            @(posedge clk);
            c += (spt === 1'b1);
        end
    endtask
    task wait_sample;
        do @(posedge clk); while (spt !== 1'b1);
    endtask
    task wrap_up;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        wrap_up;
    end
    // Main sequence
    initial begin
        void'($urandom(49));
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        rdchk("ctrl reset", CBTC_ADDR_CTRL, 32'h01);
        apb(0, 16'h0000, 8'h00);
        chk("unmapped error", 1, eseen);
        chk("unmapped data", 0, rd);
        apb(1, CBTC_ADDR_CTRL, 8'h41);
        apb(1, CBTC_ADDR_BT0, 8'h80);
        rdchk("bt0 open", CBTC_ADDR_BT0, 32'h80);
        apb(1, CBTC_ADDR_CTRL, 8'h01);
        apb(1, CBTC_ADDR_BT0, 8'h3f);
        rdchk("bt0 locked", CBTC_ADDR_BT0, 32'h80);
        apb(1, CBTC_ADDR_CTRL, 8'hff);
        rdchk("ctrl reserved", CBTC_ADDR_CTRL, 32'h4f);
        rst_n <= 0;
        @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        rdchk("bt0 kept", CBTC_ADDR_BT0, 32'h80);
        rdchk("ctrl again", CBTC_ADDR_CTRL, 32'h01);
        apb(1, CBTC_ADDR_CTRL, 8'h41);
        repeat (6) begin
            b = $urandom % 4;
            t1 = 2 + $urandom % 14;
            t2 = 1 + $urandom % 7;
            sp = $urandom % 2;
            if (t1 + t2 < 5) t2 = 5 - t1;
            apb(1, CBTC_ADDR_BT0, 8'(b));
            apb(1, CBTC_ADDR_BT1, 8'(sp * 128 + t2 * 16 + t1));
            gap(0, n);
            gap(0, n);
            chk("bit clocks", (b + 1) * (3 + t1 + t2 + 2 * sp), n);
        end
        apb(1, CBTC_ADDR_BT0, 8'h00);
        apb(1, CBTC_ADDR_BT1, 8'h24);
        apb(1, CBTC_ADDR_CTRL, 8'h00);
        join_count(n);
        chk("idle bits", 1, n >= 11 && n <= 12);
        gap(1, n);
        chk("tx period", 9, n);
        dlen <= 20;
        go <= 1;
        @(posedge clk);
        go <= 0;
        repeat (3) @(posedge clk);
        wait_sample;
        chk("rx dominant", 0, rbit);
        repeat (30) @(posedge clk);
        wait_sample;
        chk("rx recessive", 1, rbit);
        fa <= 1;
        apb(1, CBTC_ADDR_CTRL, 8'h01);
        repeat (4) @(posedge clk);
        chk("frame finishes", 1, ben);
        fa <= 0;
        repeat (3) @(posedge clk);
        chk("halted", 0, ben);
        apb(1, CBTC_ADDR_CTRL, 8'h00);
        join_count(n);
        elim <= 1;
        @(posedge clk);
        elim <= 0;
        repeat (2) @(posedge clk);
        chk("bus off", 1, boff);
        chk("off isolated", 0, ben);
        rdchk("init set", CBTC_ADDR_CTRL, 32'h01);
        chk("no early clear", 0, clr_seen);
        apb(1, CBTC_ADDR_CTRL, 8'h00);
        join_count(n);
        chk("recovery bits", 1, n >= 1408 && n <= 1409);
        chk("counters cleared", 1, clr_seen);
        // Drop the pending flag left by bus-off so the event alone sets it
        apb(1, CBTC_ADDR_STAT, 8'h02);
        eev <= 1;
        @(posedge clk);
        eev <= 0;
        apb(0, CBTC_ADDR_STAT, 8'h00);
        chk("err pending", 1, rd[1]);
        chk("no request", 0, irq);
        apb(1, CBTC_ADDR_CTRL, 8'h0a);
        chk("err request", 1, irq);
        apb(1, CBTC_ADDR_CTRL, 8'h02);
        chk("err masked", 0, irq);
        apb(1, CBTC_ADDR_STAT, 8'h02);
        sev <= 1;
        @(posedge clk);
        sev <= 0;
        apb(1, CBTC_ADDR_CTRL, 8'h06);
        chk("status request", 1, irq);
        obj <= 1;
        apb(1, CBTC_ADDR_CTRL, 8'h00);
        chk("global off", 0, irq);
        apb(1, CBTC_ADDR_CTRL, 8'h02);
        chk("object request", 1, irq);
        obj <= 0;
        wrap_up;
    end
endmodule
